// File: verif/aes_evt_src.sv
`timescale 1ns/100ps
// ----------------------------------------
// Far-side event source
// ----------------------------------------
module aes_evt_src (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] fire_corr,
  input  wire logic [4:0] fire_unc,
  output logic      [5:0] corr_evt,
  output logic      [4:0] unc_evt
);
  // The link layers raise each requested event one cycle after it is requested.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corr_evt <= 6'h00;
      unc_evt  <= 5'h00;
    end else begin
      corr_evt <= fire_corr;
      unc_evt  <= fire_unc;
    end
  end
endmodule

// File: verif/tb_aes_top.sv
`timescale 1ns/100ps
// ----------------------------------------
// Bench for the error reporting block
// ----------------------------------------
module tb_aes_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  fire_corr;
  logic [4:0]  fire_unc;
  logic [5:0]  corr_evt;
  logic [4:0]  unc_evt;
  logic        fatal_report;
  logic        nonfatal_report;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          fails;
  int          samples_checked;

  aes_top i_aes_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_error_evt(corr_evt[0]), .bad_tlp_evt(corr_evt[1]),
    .bad_dllp_evt(corr_evt[2]), .replay_rollover_evt(corr_evt[3]),
    .replay_timeout_evt(corr_evt[4]), .advisory_nf_evt(corr_evt[5]), .unc_event(unc_evt),
    .fatal_report(fatal_report), .nonfatal_report(nonfatal_report), .irq(irq));

  aes_evt_src i_aes_evt_src (.pclk(pclk), .presetn(presetn), .fire_corr(fire_corr),
    .fire_unc(fire_unc), .corr_evt(corr_evt), .unc_evt(unc_evt));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compares a value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      finish_test();
    end else begin
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Reads a register and compares it.
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Fires events through the far side; returns mid-cycle while the reports stand.
  task automatic pulse(input logic [5:0] c, input logic [4:0] u);
    @(posedge pclk);
    fire_corr <= c;
    fire_unc  <= u;
    @(posedge pclk);
    fire_corr <= 6'h00;
    fire_unc  <= 5'h00;
    @(posedge pclk);
    @(negedge pclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, read-write severity, reserved bits and an unmapped address.
  task automatic t_regs();
    rdchk(aes_pkg::OFS_SEV, 32'h00060000);
    rdchk(aes_pkg::OFS_CES, 32'h00000000);
    apb(1'b1, aes_pkg::OFS_SEV, 32'hffffffff);
    rdchk(aes_pkg::OFS_SEV, 32'h001f0000);
    apb(1'b1, aes_pkg::OFS_SEV, 32'h00000000);
    rdchk(aes_pkg::OFS_SEV, 32'h00000000);
    apb(1'b0, 12'h200, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 12'h10e, 32'hffffffff);
    chk({31'h0, er}, 32'h1);
    rdchk(aes_pkg::OFS_SEV, 32'h00000000);
  endtask

  // Each event sets only its own flag; zero writes keep it, one writes clear it.
  task automatic t_corr();
    int pos[6] = '{0, 6, 7, 8, 12, 13};
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i, 5'h00);
      rdchk(aes_pkg::OFS_CES, 32'h1 << pos[i]);
      apb(1'b1, aes_pkg::OFS_CES, 32'h00000000);
      rdchk(aes_pkg::OFS_CES, 32'h1 << pos[i]);
      apb(1'b1, aes_pkg::OFS_CES, 32'hffffffff);
      rdchk(aes_pkg::OFS_CES, 32'h00000000);
    end
    pulse(6'h3f, 5'h00);
    rdchk(aes_pkg::OFS_CES, 32'h000031c1);
    apb(1'b1, aes_pkg::OFS_CES, 32'h00000100);
    rdchk(aes_pkg::OFS_CES, 32'h000030c1);
  endtask

  // Each uncorrectable event is routed by its severity bit.
  task automatic t_route(input logic [4:0] s);
    apb(1'b1, aes_pkg::OFS_SEV, {11'h0, s, 16'h0});
    for (int i = 0; i < 5; i++) begin
      pulse(6'h00, 5'h01 << i);
      chk({30'h0, fatal_report, nonfatal_report}, {30'h0, s[i], ~s[i]});
    end
  endtask

  // Masked events take no part in severity selection and raise nothing.
  task automatic t_mask();
    apb(1'b1, aes_pkg::OFS_SEV, 32'h00060000);
    apb(1'b1, aes_pkg::OFS_UMASK, 32'h001f0000);
    pulse(6'h00, 5'h1f);
    chk({30'h0, fatal_report, nonfatal_report}, 32'h0);
    apb(1'b1, aes_pkg::OFS_UMASK, 32'h00040000);
    pulse(6'h00, 5'h1f);
    chk({30'h0, fatal_report, nonfatal_report}, 32'h3);
    apb(1'b1, aes_pkg::OFS_UMASK, 32'h00060000);
    pulse(6'h00, 5'h1f);
    chk({30'h0, fatal_report, nonfatal_report}, 32'h1);
    apb(1'b1, aes_pkg::OFS_UMASK, 32'h00000000);
  endtask

  // Interrupt raised, cleared, masked, and raised again by a fatal report.
  task automatic t_irq();
    apb(1'b1, aes_pkg::OFS_IST, 32'hffffffff);
    apb(1'b1, aes_pkg::OFS_IMSK, 32'h00000001);
    pulse(6'h02, 5'h00);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, aes_pkg::OFS_IST, 32'h00000001);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, aes_pkg::OFS_IMSK, 32'h00000000);
    pulse(6'h02, 5'h00);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, aes_pkg::OFS_IMSK, 32'h00000004);
    pulse(6'h00, 5'h02);
    chk({31'h0, irq}, 32'h0);
    @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
  endtask

  // ----------------------------------------
  // Clock and main sequence
  // ----------------------------------------
  // Free-running 10 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Reset, then every scenario in turn.
  initial begin
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 12'h000;
    pwdata          = 32'h0;
    fire_corr       = 6'h00;
    fire_unc        = 5'h00;
    fails           = 0;
    samples_checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_corr();
    t_route(5'h06);
    t_route(5'h19);
    t_mask();
    t_irq();
    finish_test();
  end
endmodule

// File: verilog/aes_pkg.sv
package aes_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int AW = 12;
  localparam int DW = 32;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [AW-1:0] OFS_UMASK = 12'h108;
  localparam logic [AW-1:0] OFS_SEV   = 12'h10c;
  localparam logic [AW-1:0] OFS_CES   = 12'h110;
  localparam logic [AW-1:0] OFS_IST   = 12'h140;
  localparam logic [AW-1:0] OFS_IMSK  = 12'h144;

  // ----------------------------------------
  // Severity and mask field, bits 20:16
  // ----------------------------------------
  localparam int SEV_LSB = 16;
  localparam int SEV_W   = 5;
  localparam logic [SEV_W-1:0] SEV_RST   = 5'h06;
  localparam logic [SEV_W-1:0] UMASK_RST = 5'h00;

  // ----------------------------------------
  // Correctable status layout
  // ----------------------------------------
  localparam int CES_W        = 14;
  localparam int CES_RXERR    = 0;
  localparam int CES_BAD_TLP  = 6;
  localparam int CES_BAD_DLLP = 7;
  localparam int CES_ROLLOVER = 8;
  localparam int CES_REPLAYTO = 12;
  localparam int CES_ADVNF    = 13;
  localparam logic [CES_W-1:0] CES_VALID = 14'h31c1;

  // ----------------------------------------
  // Interrupt status layout
  // ----------------------------------------
  localparam int IST_W        = 3;
  localparam int IST_CORR     = 0;
  localparam int IST_NONFATAL = 1;
  localparam int IST_FATAL    = 2;
  localparam logic [IST_W-1:0] IST_VALID = 3'h7;
  localparam logic [IST_W-1:0] IMSK_RST  = 3'h0;

endpackage

// File: verilog/aes_sev_router.sv
`timescale 1ns/100ps
module aes_sev_router #(
  parameter int N = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] unc_event,
  input  wire logic [N-1:0] umask,
  input  wire logic [N-1:0] sev,
  output logic              fatal_report,
  output logic              nonfatal_report
);

  typedef struct packed {
    logic fatal;
    logic nonfatal;
  } aes_rtr_t;

  aes_rtr_t     state_r;
  aes_rtr_t     state_nxt;
  logic [N-1:0] live;

  // Masked events are dropped before severity is consulted.
  always_comb begin
    live               = unc_event & ~umask;
    state_nxt.fatal    = |(live & sev);
    state_nxt.nonfatal = |(live & ~sev);
  end

  // Report pulses are registered, one cycle after the event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign fatal_report    = state_r.fatal;
  assign nonfatal_report = state_r.nonfatal;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_masked_quiet: assert property ((live == '0) |=> !fatal_report && !nonfatal_report)
    else $error("Masked event was reported.");
  a_fatal_pick: assert property (((live & sev) != '0) |=> fatal_report)
    else $error("Fatal severity event not reported fatal.");
  a_nonfatal_pick: assert property (((live & ~sev) != '0) |=> nonfatal_report)
    else $error("Non-fatal severity event not reported.");

endmodule

// File: verilog/aes_top.sv
`timescale 1ns/100ps

module aes_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_error_evt,
  input  wire logic        bad_tlp_evt,
  input  wire logic        bad_dllp_evt,
  input  wire logic        replay_rollover_evt,
  input  wire logic        replay_timeout_evt,
  input  wire logic        advisory_nf_evt,
  input  wire logic [4:0]  unc_event,
  output logic             fatal_report,
  output logic             nonfatal_report,
  output logic             irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [aes_pkg::SEV_W-1:0] sev;
    logic [aes_pkg::SEV_W-1:0] umask;
    logic [aes_pkg::IST_W-1:0] imask;
    logic [aes_pkg::DW-1:0]    prdata;
    logic                      pslverr;
  } aes_top_t;

  aes_top_t                  state_r;
  aes_top_t                  state_nxt;
  logic                      setup;
  logic                      wr_en;
  logic                      hit_umask;
  logic                      hit_sev;
  logic                      hit_ces;
  logic                      hit_ist;
  logic                      hit_imsk;
  logic                      mapped;
  logic [aes_pkg::DW-1:0]    rd_word;
  logic [aes_pkg::CES_W-1:0] ce_set;
  logic [aes_pkg::CES_W-1:0] ce_clr;
  logic [aes_pkg::CES_W-1:0] ce_q;
  logic [aes_pkg::IST_W-1:0] is_set;
  logic [aes_pkg::IST_W-1:0] is_clr;
  logic [aes_pkg::IST_W-1:0] is_q;
  logic [aes_pkg::SEV_W-1:0] wr_field;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------

  // A full compare also rejects unaligned addresses.
  always_comb begin
    hit_umask = (paddr == aes_pkg::OFS_UMASK);
    hit_sev   = (paddr == aes_pkg::OFS_SEV);
    hit_ces   = (paddr == aes_pkg::OFS_CES);
    hit_ist   = (paddr == aes_pkg::OFS_IST);
    hit_imsk  = (paddr == aes_pkg::OFS_IMSK);
    mapped    = hit_umask | hit_sev | hit_ces | hit_ist | hit_imsk;
  end

  // The slave never waits, so every access phase completes.
  assign pready = 1'b1;
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite & mapped;

  // Severity and mask writes take only bits 20:16 of the written word.
  assign wr_field = pwdata[aes_pkg::SEV_LSB +: aes_pkg::SEV_W];

  // ----------------------------------------
  // Event collection
  // ----------------------------------------

  // Each correctable event feeds its own status bit.
  always_comb begin
    ce_set = '0;
    ce_set[aes_pkg::CES_RXERR]    = rx_error_evt;
    ce_set[aes_pkg::CES_BAD_TLP]  = bad_tlp_evt;
    ce_set[aes_pkg::CES_BAD_DLLP] = bad_dllp_evt;
    ce_set[aes_pkg::CES_ROLLOVER] = replay_rollover_evt;
    ce_set[aes_pkg::CES_REPLAYTO] = replay_timeout_evt;
    ce_set[aes_pkg::CES_ADVNF]    = advisory_nf_evt;
  end

  // Write-one clears for status; reserved bits are dropped by the bank.
  always_comb begin
    ce_clr = '0;
    is_clr = '0;
    if (wr_en && hit_ces) begin
      ce_clr = pwdata[aes_pkg::CES_W-1:0];
    end
    if (wr_en && hit_ist) begin
      is_clr = pwdata[aes_pkg::IST_W-1:0];
    end
  end

  // Interrupt causes: any correctable event and each report kind.
  always_comb begin
    is_set = '0;
    is_set[aes_pkg::IST_CORR]     = |ce_set;
    is_set[aes_pkg::IST_NONFATAL] = nonfatal_report;
    is_set[aes_pkg::IST_FATAL]    = fatal_report;
  end

  // ----------------------------------------
  // Sticky banks and severity routing
  // ----------------------------------------

  // Correctable error flags.
  aes_w1c_bank #(
    .W     (aes_pkg::CES_W),
    .VALID (aes_pkg::CES_VALID)
  ) u_ces (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (ce_set),
    .clr     (ce_clr),
    .q       (ce_q)
  );

  // Interrupt cause flags.
  aes_w1c_bank #(
    .W     (aes_pkg::IST_W),
    .VALID (aes_pkg::IST_VALID)
  ) u_ist (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (is_set),
    .clr     (is_clr),
    .q       (is_q)
  );

  // Uncorrectable events pass mask, then severity.
  aes_sev_router #(
    .N (aes_pkg::SEV_W)
  ) u_rtr (
    .pclk            (pclk),
    .presetn         (presetn),
    .unc_event       (unc_event),
    .umask           (state_r.umask),
    .sev             (state_r.sev),
    .fatal_report    (fatal_report),
    .nonfatal_report (nonfatal_report)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------

  // Unused bit positions stay zero in every word.
  always_comb begin
    rd_word = '0;
    if (hit_umask) begin
      rd_word[aes_pkg::SEV_LSB +: aes_pkg::SEV_W] = state_r.umask;
    end
    if (hit_sev) begin
      rd_word[aes_pkg::SEV_LSB +: aes_pkg::SEV_W] = state_r.sev;
    end
    if (hit_ces) begin
      rd_word[aes_pkg::CES_W-1:0] = ce_q;
    end
    if (hit_ist) begin
      rd_word[aes_pkg::IST_W-1:0] = is_q;
    end
    if (hit_imsk) begin
      rd_word[aes_pkg::IST_W-1:0] = state_r.imask;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------

  // Read data and error are captured in the setup cycle.
  always_comb begin
    state_nxt = state_r;
    if (setup) begin
      state_nxt.prdata  = pwrite ? '0 : rd_word;
      state_nxt.pslverr = ~mapped;
    end
    if (wr_en && hit_sev) begin
      state_nxt.sev = wr_field;
    end
    if (wr_en && hit_umask) begin
      state_nxt.umask = wr_field;
    end
    if (wr_en && hit_imsk) begin
      state_nxt.imask = pwdata[aes_pkg::IST_W-1:0];
    end
  end

  // Severity resets to fatal for overflow and malformed only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r         <= '0;
      state_r.sev     <= aes_pkg::SEV_RST;
      state_r.umask   <= aes_pkg::UMASK_RST;
      state_r.imask   <= aes_pkg::IMSK_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Error is shown only while the access phase is up.
  assign prdata  = state_r.prdata;
  assign pslverr = state_r.pslverr & psel & penable;
  assign irq     = |(is_q & state_r.imask);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rx_flag: assert property (rx_error_evt |=> ce_q[aes_pkg::CES_RXERR])
    else $error("Receiver error flag not set.");
  a_tlp_flag: assert property (bad_tlp_evt |=> ce_q[aes_pkg::CES_BAD_TLP])
    else $error("Bad packet flag not set.");
  a_dllp_flag: assert property (bad_dllp_evt |=> ce_q[aes_pkg::CES_BAD_DLLP])
    else $error("Bad link packet flag not set.");
  a_roll_flag: assert property (replay_rollover_evt |=> ce_q[aes_pkg::CES_ROLLOVER])
    else $error("Rollover flag not set.");
  a_timer_flag: assert property (replay_timeout_evt |=> ce_q[aes_pkg::CES_REPLAYTO])
    else $error("Replay timeout flag not set.");
  a_advnf_flag: assert property (advisory_nf_evt |=> ce_q[aes_pkg::CES_ADVNF])
    else $error("Advisory flag not set.");

  a_zero_keeps: assert property ((wr_en && hit_ces && (pwdata[aes_pkg::CES_W-1:0] == '0))
                                 |=> (ce_q & $past(ce_q)) == $past(ce_q))
    else $error("Zero write changed a status flag.");

  a_sev_reads: assert property ((setup && !pwrite && hit_sev) |=>
                                prdata == {11'h000, $past(state_r.sev), 16'h0000})
    else $error("Severity word read back wrong.");

  a_ces_reads: assert property ((setup && !pwrite && hit_ces) |=>
                                (prdata & ~32'h000031c1) == 32'h00000000)
    else $error("Reserved status bits read non-zero.");

  a_sev_write: assert property (wr_en && hit_sev |=> state_r.sev == $past(wr_field))
    else $error("Severity write did not store.");

  a_mask_blocks: assert property (((unc_event & state_r.umask) == unc_event)
                                  |=> !fatal_report && !nonfatal_report)
    else $error("Masked uncorrectable event reported.");

  a_bad_addr: assert property ((psel && !penable && !mapped) |=> pslverr)
    else $error("Unmapped address not flagged.");

  a_irq_level: assert property ((fatal_report && state_r.imask[aes_pkg::IST_FATAL]
                                 && !(wr_en && hit_imsk)) |=> irq)
    else $error("Interrupt low with pending cause.");

  // ----------------------------------------
  // Bus and register checks
  // ----------------------------------------

  // Every access phase is answered at once.
  a_no_wait: assert property ((psel && penable) |-> pready)
    else $error("Access phase saw pready low.");

  // Read data is not disturbed by the access edge.
  a_rdata_hold: assert property ((psel && penable) |=> $stable(prdata))
    else $error("Read data moved during access.");

  // A mapped address answers without error.
  a_ok_mapped: assert property ((psel && !penable && mapped) |=> !pslverr)
    else $error("Mapped address flagged as error.");

  // Unmapped reads and all writes return a zero word.
  a_bad_zero: assert property ((psel && !penable && !mapped) |=> (prdata == '0))
    else $error("Unmapped read returned data.");
  a_wr_zero: assert property ((setup && pwrite) |=> (prdata == '0))
    else $error("Write cycle left read data.");

  // A write to an unmapped address changes no register.
  a_bad_write: assert property ((psel && penable && pwrite && !mapped) |=>
                                $stable(state_r.sev) && $stable(state_r.umask)
                                && $stable(state_r.imask))
    else $error("Unmapped write changed a register.");

  // Mask writes store the written field.
  a_umask_write: assert property ((wr_en && hit_umask) |=>
                                  state_r.umask == $past(wr_field))
    else $error("Mask write did not store.");
  a_imask_write: assert property ((wr_en && hit_imsk) |=>
                                  state_r.imask == $past(pwdata[aes_pkg::IST_W-1:0]))
    else $error("Interrupt mask write did not store.");

  // Sticky severity and mask change only by a register write.
  a_sev_hold: assert property (!(wr_en && hit_sev) |=> $stable(state_r.sev))
    else $error("Severity changed without a write.");
  a_umask_hold: assert property (!(wr_en && hit_umask) |=> $stable(state_r.umask))
    else $error("Mask changed without a write.");

  // ----------------------------------------
  // Interrupt cause checks
  // ----------------------------------------

  // Each report and any correctable event leaves its interrupt cause.
  a_corr_cause: assert property ((ce_set != '0) |=> is_q[aes_pkg::IST_CORR])
    else $error("Correctable event left no interrupt cause.");
  a_nf_cause: assert property (nonfatal_report |=> is_q[aes_pkg::IST_NONFATAL])
    else $error("Non-fatal report left no interrupt cause.");
  a_fatal_cause: assert property (fatal_report |=> is_q[aes_pkg::IST_FATAL])
    else $error("Fatal report left no interrupt cause.");

  // Writing one to the fatal cause clears it when no new fatal report arrives.
  a_ist_clear: assert property ((wr_en && hit_ist && pwdata[aes_pkg::IST_FATAL] && !fatal_report)
                                |=> !is_q[aes_pkg::IST_FATAL])
    else $error("Fatal cause not cleared by write.");

  c_fatal: cover property (fatal_report);
  c_nonfatal: cover property (nonfatal_report);
  c_clear_race: cover property (wr_en && hit_ces && ((ce_set & pwdata[aes_pkg::CES_W-1:0]) != '0));
  c_irq: cover property ($rose(irq));

endmodule

// File: verilog/aes_w1c_bank.sv
`timescale 1ns/100ps
module aes_w1c_bank #(
  parameter int       W     = 14,
  parameter logic [W-1:0] VALID = '1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] q;
  } aes_bank_t;

  aes_bank_t    state_r;
  aes_bank_t    state_nxt;
  logic [W-1:0] set_v;
  logic [W-1:0] clr_only;

  // Set beats a clear that lands in the same cycle.
  always_comb begin
    set_v         = set & VALID;
    clr_only      = clr & ~set_v;
    state_nxt.q   = ((state_r.q & ~clr) | set_v) & VALID;
  end

  // Flags stay at zero after reset until an event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign q = state_r.q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_set_sticks: assert property ((set_v != '0) |=> ((q & $past(set_v)) == $past(set_v)))
    else $error("Event did not set its flag.");
  a_clear_one: assert property ((clr_only != '0) |=> ((q & $past(clr_only)) == '0))
    else $error("Write of one did not clear flag.");
  a_no_ghost: assert property (((q & ~$past(q)) & ~$past(set_v)) == '0)
    else $error("Flag rose without an event.");
  a_keep_zero: assert property (((q & ~VALID) == '0))
    else $error("Reserved flag bit is set.");

endmodule
